// ---- design/tmc_timer0_ctrl.sv ----
// timer0 waveform mode decode, force strobes, clock select, prescaler control and interrupt requests
`timescale 1ns/1ps
`include "tmc_defs.svh"

// Summary of operation
// - waveform mode is high bit of control b over two low bits of control a.
// - mode 0 counts to 0xff, updates compares immediately, overflow flag at 0xff.
// - modes 1 and 5 top 0xff or compare a, latch at top, overflow at bottom.
// - mode 2 top compare a, immediate update, overflow when count passes 0xff.
// - modes 3 and 7 top 0xff or compare a, latch at bottom, overflow max or top.
// - force bit in non-pwm mode gives an immediate match at that channel's generator.
// - force ignored in pwm; it sets no flag and never clears the counter.
// - force bits are unstored strobes and always read as zero.
// - clock select 0 stops; 1 to 5 pick io clock over 1,8,64,256,1024.
// - codes 6 and 7 count external pin falling or rising edges, synchronously sampled.
// - external pin edges count even while that pin is driven as an output.
// - interrupt requested when enable bit, global enable and matching flag are set.
// - while sync hold set, both prescaler reset bits hold and resets stay asserted.
// - clearing sync hold clears the sync reset bit; the async one clears only outside async mode or once async reset is done.
// - async prescaler reset self-clears, in async mode waits for async completion, never clears under hold.
// - sync prescaler reset clears the shared prescaler, self-clears unless hold is set.
// - each flag clears on vector execution or writing one; writing zero keeps it.
module tmc_timer0_ctrl #(
    parameter int PRESCALE_WIDTH = `TMC_PRESCALE_WIDTH
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    input wire logic [7:0] bus_addr_in,
    input wire logic [7:0] bus_wdata_in,
    input wire logic global_irq_enable_in,
    input wire logic external_count_pin_in,
    input wire logic async_reset_done_in,
    input wire logic async_mode_in,
    input wire tmc_pkg::tmc_events_t events_in,
    input wire tmc_pkg::tmc_events_t vector_ack_in,
    output logic [7:0] bus_rdata_out,
    output logic [2:0] wave_mode_out,
    output tmc_pkg::tmc_mode_info_t mode_info_out,
    output logic [1:0] compare_out_mode_a_out,
    output logic [1:0] compare_out_mode_b_out,
    output logic force_compare_a_out,
    output logic force_compare_b_out,
    output logic count_enable_out,
    output logic sync_prescaler_reset_out,
    output logic async_prescaler_reset_out,
    output tmc_pkg::tmc_events_t flags_out,
    output tmc_pkg::tmc_events_t irq_req_out
);

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic [7:0] timer0_control_a;
    logic [7:0] timer0_control_b;
    logic [7:0] timer0_interrupt_mask;
    logic sync_hold_mode;
    logic async_prescaler_reset;
    logic sync_prescaler_reset;
    tmc_pkg::tmc_events_t flags;
    logic [PRESCALE_WIDTH-1:0] prescale_count;
    logic [2:0] pin_sync;
    logic pin_level;

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    wire wr_ctrl_a = bus_wr_in && (bus_addr_in == `TMC_ADDR_CTRL_A);
    wire wr_ctrl_b = bus_wr_in && (bus_addr_in == `TMC_ADDR_CTRL_B);
    wire wr_mask = bus_wr_in && (bus_addr_in == `TMC_ADDR_IRQ_MASK);
    wire wr_gen = bus_wr_in && (bus_addr_in == `TMC_ADDR_GEN_CTRL);
    wire wr_flags = bus_wr_in && (bus_addr_in == `TMC_ADDR_FLAGS);

    ////////////////////////////////////////////////////////////////////////////
    // waveform mode decode
    wire wave_mode_high_bit = timer0_control_b[`TMC_BIT_WAVE_HIGH];
    wire wave_mode_bit1 = timer0_control_a[1];
    wire wave_mode_bit0 = timer0_control_a[0];
    wire [2:0] next_wave_mode = {wave_mode_high_bit, wave_mode_bit1, wave_mode_bit0};
    tmc_pkg::tmc_mode_info_t next_mode_info;

    always_comb begin
        next_mode_info.is_pwm = 1'b1;
        next_mode_info.phase_correct = 1'b0;
        next_mode_info.top_src = tmc_pkg::TMC_TOP_NONE;
        next_mode_info.update_point = tmc_pkg::TMC_UPD_IMMEDIATE;
        next_mode_info.ovf_point = tmc_pkg::TMC_OVF_NEVER;
        case (tmc_pkg::tmc_wave_mode_t'(next_wave_mode))
            tmc_pkg::TMC_WAVE_NORMAL: begin
                next_mode_info.is_pwm = 1'b0;
                next_mode_info.top_src = tmc_pkg::TMC_TOP_FIXED;
                next_mode_info.ovf_point = tmc_pkg::TMC_OVF_AT_MAX;
            end
            tmc_pkg::TMC_WAVE_PC_FULL, tmc_pkg::TMC_WAVE_PC_CMPA: begin
                next_mode_info.phase_correct = 1'b1;
                next_mode_info.top_src = next_wave_mode[2] ? tmc_pkg::TMC_TOP_CMPA : tmc_pkg::TMC_TOP_FIXED;
                next_mode_info.update_point = tmc_pkg::TMC_UPD_AT_TOP;
                next_mode_info.ovf_point = tmc_pkg::TMC_OVF_AT_BOTTOM;
            end
            tmc_pkg::TMC_WAVE_CTC: begin
                next_mode_info.is_pwm = 1'b0;
                next_mode_info.top_src = tmc_pkg::TMC_TOP_CMPA;
                next_mode_info.ovf_point = tmc_pkg::TMC_OVF_AT_MAX;
            end
            tmc_pkg::TMC_WAVE_FAST_FULL: begin
                next_mode_info.top_src = tmc_pkg::TMC_TOP_FIXED;
                next_mode_info.update_point = tmc_pkg::TMC_UPD_AT_BOTTOM;
                next_mode_info.ovf_point = tmc_pkg::TMC_OVF_AT_MAX;
            end
            tmc_pkg::TMC_WAVE_FAST_CMPA: begin
                next_mode_info.top_src = tmc_pkg::TMC_TOP_CMPA;
                next_mode_info.update_point = tmc_pkg::TMC_UPD_AT_BOTTOM;
                next_mode_info.ovf_point = tmc_pkg::TMC_OVF_AT_TOP;
            end
            default: begin
                // reserved codes: treated as pwm so force strobes stay inert
                next_mode_info.top_src = tmc_pkg::TMC_TOP_NONE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // force strobes, only honoured in non-pwm modes
    wire next_force_a = wr_ctrl_b && bus_wdata_in[`TMC_BIT_FORCE_A] && !next_mode_info.is_pwm;
    wire next_force_b = wr_ctrl_b && bus_wdata_in[`TMC_BIT_FORCE_B] && !next_mode_info.is_pwm;

    ////////////////////////////////////////////////////////////////////////////
    // prescaler and clock select
    wire [2:0] clock_select = timer0_control_b[2:0];
    wire [PRESCALE_WIDTH-1:0] next_prescale = prescale_count + {{(PRESCALE_WIDTH-1){1'b0}}, 1'b1};
    // a tap fires when all its low bits roll over, giving one pulse per period
    wire tap_8 = &prescale_count[2:0];
    wire tap_64 = &prescale_count[5:0];
    wire tap_256 = &prescale_count[7:0];
    wire tap_1024 = &prescale_count[9:0];
    wire pin_rise = pin_level == 1'b0 && pin_sync[2:1] == 2'b11;
    wire pin_fall = pin_level == 1'b1 && pin_sync[2:1] == 2'b00;
    logic next_count_enable;

    always_comb begin
        case (clock_select)
            3'h0: next_count_enable = 1'b0;
            3'h1: next_count_enable = 1'b1;
            3'h2: next_count_enable = tap_8;
            3'h3: next_count_enable = tap_64;
            3'h4: next_count_enable = tap_256;
            3'h5: next_count_enable = tap_1024;
            3'h6: next_count_enable = pin_fall;
            3'h7: next_count_enable = pin_rise;
            default: next_count_enable = 1'b0;
        endcase
    end

    // prescaled codes also halt while the shared prescaler is held in reset
    wire prescaled_sel = clock_select != 3'h0 && clock_select < 3'h6;
    wire count_gate = next_count_enable && !(prescaled_sel && sync_prescaler_reset);

    ////////////////////////////////////////////////////////////////////////////
    // general control next values
    logic next_sync_hold;
    logic next_async_reset;
    logic next_sync_reset;

    always_comb begin
        next_sync_hold = sync_hold_mode;
        next_async_reset = async_prescaler_reset;
        next_sync_reset = sync_prescaler_reset;
        if (wr_gen) begin
            next_sync_hold = bus_wdata_in[`TMC_BIT_SYNC_HOLD];
            next_async_reset = async_prescaler_reset | bus_wdata_in[`TMC_BIT_ASYNC_RST];
            next_sync_reset = sync_prescaler_reset | bus_wdata_in[`TMC_BIT_SYNC_RST];
        end
        if (!next_sync_hold) begin
            // self-clear once the reset has acted; hold mode blocks it
            next_sync_reset = 1'b0;
            if (!async_mode_in || async_reset_done_in) begin
                next_async_reset = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flags: a set in the same cycle as a clear wins
    tmc_pkg::tmc_events_t flag_clear;
    assign flag_clear = (wr_flags ? bus_wdata_in[2:0] : 3'h0) | vector_ack_in;
    wire [2:0] next_flags = events_in | (flags & ~flag_clear);
    wire [2:0] next_irq = next_flags & timer0_interrupt_mask[2:0] & {3{global_irq_enable_in}};

    ////////////////////////////////////////////////////////////////////////////
    // read mux, force bits never stored so they read as zero
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        if (bus_rd_in) begin
            case (bus_addr_in)
                `TMC_ADDR_CTRL_A: next_rdata = timer0_control_a;
                `TMC_ADDR_CTRL_B: next_rdata = timer0_control_b;
                `TMC_ADDR_IRQ_MASK: next_rdata = timer0_interrupt_mask;
                `TMC_ADDR_GEN_CTRL: next_rdata = {sync_hold_mode, 5'h00, async_prescaler_reset, sync_prescaler_reset};
                `TMC_ADDR_FLAGS: next_rdata = {5'h00, flags};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            timer0_control_a <= `TMC_RST_BYTE;
            timer0_control_b <= `TMC_RST_BYTE;
            timer0_interrupt_mask <= `TMC_RST_BYTE;
        end else begin
            if (wr_ctrl_a) timer0_control_a <= bus_wdata_in & `TMC_CTRL_A_MASK;
            if (wr_ctrl_b) timer0_control_b <= bus_wdata_in & `TMC_CTRL_B_MASK;
            if (wr_mask) timer0_interrupt_mask <= bus_wdata_in & `TMC_IRQ_MASK_BITS;
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sync_hold_mode <= 1'b0;
            async_prescaler_reset <= 1'b0;
            sync_prescaler_reset <= 1'b0;
            flags <= 3'h0;
        end else begin
            sync_hold_mode <= next_sync_hold;
            async_prescaler_reset <= next_async_reset;
            sync_prescaler_reset <= next_sync_reset;
            flags <= next_flags;
        end
    end

    // free counter shared by timers 0 and 1, cleared by the sync reset
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prescale_count <= '0;
        end else if (sync_prescaler_reset || (wr_gen && bus_wdata_in[`TMC_BIT_SYNC_RST])) begin
            prescale_count <= '0;
        end else begin
            prescale_count <= next_prescale;
        end
    end

    // pin sampled regardless of its port direction
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pin_sync <= 3'h0;
            pin_level <= 1'b0;
        end else begin
            pin_sync <= {pin_sync[1:0], external_count_pin_in};
            if (pin_sync[2] == pin_sync[1]) pin_level <= pin_sync[2];
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bus_rdata_out <= 8'h00;
            wave_mode_out <= 3'h0;
            mode_info_out <= '0;
            compare_out_mode_a_out <= 2'h0;
            compare_out_mode_b_out <= 2'h0;
            force_compare_a_out <= 1'b0;
            force_compare_b_out <= 1'b0;
            count_enable_out <= 1'b0;
            sync_prescaler_reset_out <= 1'b0;
            async_prescaler_reset_out <= 1'b0;
            flags_out <= 3'h0;
            irq_req_out <= 3'h0;
        end else begin
            bus_rdata_out <= next_rdata;
            wave_mode_out <= next_wave_mode;
            mode_info_out <= next_mode_info;
            compare_out_mode_a_out <= timer0_control_a[7:6];
            compare_out_mode_b_out <= timer0_control_a[5:4];
            force_compare_a_out <= next_force_a;
            force_compare_b_out <= next_force_b;
            count_enable_out <= count_gate;
            sync_prescaler_reset_out <= next_sync_reset || (wr_gen && bus_wdata_in[`TMC_BIT_SYNC_RST]);
            async_prescaler_reset_out <= next_async_reset || (wr_gen && bus_wdata_in[`TMC_BIT_ASYNC_RST]);
            flags_out <= next_flags;
            irq_req_out <= next_irq;
        end
    end

endmodule : tmc_timer0_ctrl

// ---- design/tmc_defs.svh ----
// register offsets, field positions, reset values and counts for the timer0 mode and clock control
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH
`define TMC_ADDR_GEN_CTRL 8'h43
`define TMC_ADDR_CTRL_A 8'h44
`define TMC_ADDR_CTRL_B 8'h45
`define TMC_ADDR_FLAGS 8'h35
`define TMC_ADDR_IRQ_MASK 8'h6e
`define TMC_RST_BYTE 8'h00
`define TMC_BIT_FORCE_A 7
`define TMC_BIT_FORCE_B 6
`define TMC_BIT_WAVE_HIGH 3
`define TMC_BIT_SYNC_HOLD 7
`define TMC_BIT_ASYNC_RST 1
`define TMC_BIT_SYNC_RST 0
`define TMC_BIT_OVF 0
`define TMC_BIT_CMP_A 1
`define TMC_BIT_CMP_B 2
`define TMC_CTRL_A_MASK 8'hf3
`define TMC_CTRL_B_MASK 8'h0f
`define TMC_GEN_MASK 8'h83
`define TMC_IRQ_MASK_BITS 8'h07
`define TMC_MAX_VALUE 8'hff
`define TMC_BOTTOM_VALUE 8'h00
`define TMC_PRESCALE_WIDTH 10
`endif

// ---- design/tmc_pkg.sv ----
// types for the timer0 mode and clock control
package tmc_pkg;
    typedef enum logic [2:0] {
        TMC_WAVE_NORMAL = 3'h0,
        TMC_WAVE_PC_FULL = 3'h1,
        TMC_WAVE_CTC = 3'h2,
        TMC_WAVE_FAST_FULL = 3'h3,
        TMC_WAVE_RSVD4 = 3'h4,
        TMC_WAVE_PC_CMPA = 3'h5,
        TMC_WAVE_RSVD6 = 3'h6,
        TMC_WAVE_FAST_CMPA = 3'h7
    } tmc_wave_mode_t;
    typedef enum logic [3:0] {
        TMC_TOP_FIXED = 4'h1,
        TMC_TOP_CMPA = 4'h2,
        TMC_TOP_NONE = 4'h4,
        TMC_TOP_UNUSED = 4'h8
    } tmc_top_src_t;
    typedef enum logic [2:0] {
        TMC_UPD_IMMEDIATE = 3'h1,
        TMC_UPD_AT_TOP = 3'h2,
        TMC_UPD_AT_BOTTOM = 3'h4
    } tmc_update_t;
    typedef enum logic [3:0] {
        TMC_OVF_AT_MAX = 4'h1,
        TMC_OVF_AT_BOTTOM = 4'h2,
        TMC_OVF_AT_TOP = 4'h4,
        TMC_OVF_NEVER = 4'h8
    } tmc_ovf_t;
    typedef struct packed {
        tmc_top_src_t top_src;
        tmc_update_t update_point;
        tmc_ovf_t ovf_point;
        logic is_pwm;
        logic phase_correct;
    } tmc_mode_info_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tmc_bus_req_t;
    typedef struct packed {
        logic compare_b;
        logic compare_a;
        logic overflow;
    } tmc_events_t;
endpackage : tmc_pkg

// ---- test/tmc_timer0_ctrl_properties.sv ----
// concurrent checks on the ports of the timer0 mode and clock control
`timescale 1ns/1ps
module tmc_timer0_ctrl_properties #(
    parameter int PRESCALE_WIDTH = 10
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    input wire logic [7:0] bus_addr_in,
    input wire logic [7:0] bus_wdata_in,
    input wire logic global_irq_enable_in,
    input wire logic external_count_pin_in,
    input wire logic async_reset_done_in,
    input wire logic async_mode_in,
    input wire tmc_pkg::tmc_events_t events_in,
    input wire tmc_pkg::tmc_events_t vector_ack_in,
    input wire logic [7:0] bus_rdata_out,
    input wire logic [2:0] wave_mode_out,
    input wire tmc_pkg::tmc_mode_info_t mode_info_out,
    input wire logic [1:0] compare_out_mode_a_out,
    input wire logic [1:0] compare_out_mode_b_out,
    input wire logic force_compare_a_out,
    input wire logic force_compare_b_out,
    input wire logic count_enable_out,
    input wire logic sync_prescaler_reset_out,
    input wire logic async_prescaler_reset_out,
    input wire tmc_pkg::tmc_events_t flags_out,
    input wire tmc_pkg::tmc_events_t irq_req_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    logic wr_b;
    logic wr_gen;
    // stored mode is pwm or reserved when its high bit or low bit is set
    assign wr_b = bus_wr_in && bus_addr_in == 8'h45;
    assign wr_gen = bus_wr_in && bus_addr_in == 8'h43;
    sequence s_sync_pulse;
        sync_prescaler_reset_out ##1 !sync_prescaler_reset_out;
    endsequence
    sequence s_sync_held;
        sync_prescaler_reset_out [*4];
    endsequence
    ////////////////////////////////////////////////////////////////////////
    chk_mode_pwm: assert property (mode_info_out.top_src != 4'h0 |->
        mode_info_out.is_pwm == !(wave_mode_out inside {3'h0, 3'h2})) else $error("pwm decode wrong");
    chk_mode_ctc: assert property (mode_info_out.top_src != 4'h0 && wave_mode_out == 3'h2 |->
        mode_info_out.top_src == tmc_pkg::TMC_TOP_CMPA) else $error("ctc top wrong");
    chk_force_a: assert property (wr_b && bus_wdata_in[7] && !wave_mode_out[2] && !wave_mode_out[0]
        |=> force_compare_a_out) else $error("force a missing");
    chk_force_b: assert property (wr_b && bus_wdata_in[6] && !wave_mode_out[2] && !wave_mode_out[0]
        |=> force_compare_b_out) else $error("force b missing");
    chk_force_pwm: assert property (wr_b && (wave_mode_out[2] || wave_mode_out[0])
        |=> !force_compare_a_out && !force_compare_b_out) else $error("force in pwm mode");
    chk_force_cause: assert property (force_compare_a_out || force_compare_b_out
        |-> $past(wr_b)) else $error("force without write");
    chk_flag_set: assert property (events_in != 3'h0
        |=> (flags_out & $past(events_in)) == $past(events_in)) else $error("flag not set");
    chk_flag_clear: assert property (vector_ack_in.compare_a && !events_in.compare_a
        |=> !flags_out.compare_a) else $error("flag not cleared");
    chk_irq_global: assert property (!global_irq_enable_in
        |=> irq_req_out == 3'h0) else $error("irq without global enable");
    chk_sync_pulse: assert property (wr_gen && bus_wdata_in == 8'h01
        |=> s_sync_pulse) else $error("sync reset not self clearing");
    chk_sync_hold: assert property (wr_gen && bus_wdata_in == 8'h81
        |=> s_sync_held) else $error("sync reset not held");
    chk_sync_release: assert property (wr_gen && bus_wdata_in == 8'h00
        |=> !sync_prescaler_reset_out && (!async_prescaler_reset_out || ($past(async_mode_in) &&
        !$past(async_reset_done_in)))) else $error("hold release wrong");
endmodule : tmc_timer0_ctrl_properties

bind tmc_timer0_ctrl tmc_timer0_ctrl_properties #(.PRESCALE_WIDTH(PRESCALE_WIDTH)) tmc_timer0_ctrl_properties_inst (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
    .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in), .global_irq_enable_in(global_irq_enable_in),
    .external_count_pin_in(external_count_pin_in), .async_reset_done_in(async_reset_done_in),
    .async_mode_in(async_mode_in), .events_in(events_in), .vector_ack_in(vector_ack_in),
    .bus_rdata_out(bus_rdata_out), .wave_mode_out(wave_mode_out), .mode_info_out(mode_info_out),
    .compare_out_mode_a_out(compare_out_mode_a_out), .compare_out_mode_b_out(compare_out_mode_b_out),
    .force_compare_a_out(force_compare_a_out), .force_compare_b_out(force_compare_b_out),
    .count_enable_out(count_enable_out), .sync_prescaler_reset_out(sync_prescaler_reset_out),
    .async_prescaler_reset_out(async_prescaler_reset_out), .flags_out(flags_out), .irq_req_out(irq_req_out));

// ---- test/tmc_timer0_ctrl_tb.sv ----
// self-checking bench for the timer0 mode and clock control
`timescale 1ns/1ps
module tmc_timer0_ctrl_tb;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic bus_wr_in = 1'b0;
    logic bus_rd_in = 1'b0;
    logic [7:0] bus_addr_in = 8'h00;
    logic [7:0] bus_wdata_in = 8'h00;
    logic global_irq_enable_in = 1'b0;
    logic external_count_pin_in = 1'b0;
    logic async_reset_done_in = 1'b0;
    logic async_mode_in = 1'b0;
    tmc_pkg::tmc_events_t events_in = 3'h0;
    tmc_pkg::tmc_events_t vector_ack_in = 3'h0;
    logic [7:0] bus_rdata_out;
    logic [2:0] wave_mode_out;
    tmc_pkg::tmc_mode_info_t mode_info_out;
    logic [1:0] compare_out_mode_a_out;
    logic [1:0] compare_out_mode_b_out;
    logic force_compare_a_out;
    logic force_compare_b_out;
    logic count_enable_out;
    logic sync_prescaler_reset_out;
    logic async_prescaler_reset_out;
    tmc_pkg::tmc_events_t flags_out;
    tmc_pkg::tmc_events_t irq_req_out;
    int mismatches = 0;
    int checked = 0;
    int ticks;
    int total;
    int force_a_seen = 0;
    int force_b_seen = 0;
    logic [7:0] lfsr = 8'h46;
    tmc_pkg::tmc_mode_info_t exp_mi;
    logic [7:0] addrs [6] = '{8'h43, 8'h44, 8'h45, 8'h6e, 8'h35, 8'h50};
    int shifts [6] = '{0, 0, 3, 6, 8, 10};
    always #10 mclk_in = ~mclk_in;
    // force pulses stand one cycle, so they are counted at every edge
    always @(posedge mclk_in) begin
        if (force_compare_a_out === 1'b1) force_a_seen++;
        if (force_compare_b_out === 1'b1) force_b_seen++;
    end
    tmc_timer0_ctrl #(.PRESCALE_WIDTH(10)) tmc_timer0_ctrl_inst (
        .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
        .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in), .global_irq_enable_in(global_irq_enable_in),
        .external_count_pin_in(external_count_pin_in), .async_reset_done_in(async_reset_done_in),
        .async_mode_in(async_mode_in), .events_in(events_in), .vector_ack_in(vector_ack_in),
        .bus_rdata_out(bus_rdata_out), .wave_mode_out(wave_mode_out), .mode_info_out(mode_info_out),
        .compare_out_mode_a_out(compare_out_mode_a_out), .compare_out_mode_b_out(compare_out_mode_b_out),
        .force_compare_a_out(force_compare_a_out), .force_compare_b_out(force_compare_b_out),
        .count_enable_out(count_enable_out), .sync_prescaler_reset_out(sync_prescaler_reset_out),
        .async_prescaler_reset_out(async_prescaler_reset_out), .flags_out(flags_out), .irq_req_out(irq_req_out));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] next_rand(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : next_rand
    function automatic tmc_pkg::tmc_mode_info_t exp_mode(input logic [2:0] m);
        tmc_pkg::tmc_mode_info_t e;
        logic rsvd;
        logic pc;
        rsvd = (m == 3'h4 || m == 3'h6);
        pc = (m == 3'h1 || m == 3'h5);
        e.is_pwm = !(m == 3'h0 || m == 3'h2);
        e.phase_correct = pc;
        e.top_src = rsvd ? tmc_pkg::TMC_TOP_NONE : (m == 3'h2 || m[2]) ? tmc_pkg::TMC_TOP_CMPA : tmc_pkg::TMC_TOP_FIXED;
        e.update_point = !e.is_pwm ? tmc_pkg::TMC_UPD_IMMEDIATE : pc ? tmc_pkg::TMC_UPD_AT_TOP : tmc_pkg::TMC_UPD_AT_BOTTOM;
        e.ovf_point = rsvd ? tmc_pkg::TMC_OVF_NEVER : pc ? tmc_pkg::TMC_OVF_AT_BOTTOM :
            (m == 3'h7) ? tmc_pkg::TMC_OVF_AT_TOP : tmc_pkg::TMC_OVF_AT_MAX;
        return e;
    endfunction : exp_mode
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        bus_wr_in <= 1'b1;
        bus_addr_in <= a;
        bus_wdata_in <= d;
        @(posedge mclk_in);
        bus_wr_in <= 1'b0;
        @(posedge mclk_in);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_in);
        bus_rd_in <= 1'b1;
        bus_addr_in <= a;
        @(posedge mclk_in);
        bus_rd_in <= 1'b0;
        #1;
        cmp(bus_rdata_out, exp);
    endtask : rd
    // samples 1 ns after each edge so launched updates have landed
    task automatic count_ticks(input int n);
        ticks = 0;
        repeat (n) begin
            @(posedge mclk_in);
            #1;
            if (count_enable_out === 1'b1) ticks++;
        end
    endtask : count_ticks
    task automatic end_sim();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #1000000;
        mismatches++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        foreach (addrs[i]) rd(addrs[i], 8'h00);
        $display("reset values done");
        for (int m = 0; m < 8; m++) begin
            lfsr = next_rand(lfsr);
            wr(8'h44, {lfsr[7:4], 2'b00, m[1:0]});
            wr(8'h45, {4'h0, m[2], 3'h0});
            exp_mi = exp_mode(m[2:0]);
            cmp(wave_mode_out, m[2:0]);
            cmp({compare_out_mode_a_out, compare_out_mode_b_out}, lfsr[7:4]);
            cmp({mode_info_out.top_src, mode_info_out.ovf_point, mode_info_out.is_pwm},
                {exp_mi.top_src, exp_mi.ovf_point, exp_mi.is_pwm});
            if (m != 4 && m != 6) cmp({mode_info_out.update_point, mode_info_out.phase_correct},
                {exp_mi.update_point, exp_mi.phase_correct});
            rd(8'h44, {lfsr[7:4], 2'b00, m[1:0]});
        end
        $display("mode decode done");
        wr(8'h44, 8'h00);
        wr(8'h45, 8'h00);
        wr(8'h45, 8'hc0);
        cmp({force_a_seen[7:0], force_b_seen[7:0]}, 16'h0101);
        rd(8'h45, 8'h00);
        wr(8'h44, 8'h03);
        wr(8'h45, 8'hc0);
        cmp({force_a_seen[7:0], force_b_seen[7:0]}, 16'h0101);
        cmp(flags_out, 3'h0);
        wr(8'h44, 8'h00);
        $display("force strobes done");
        for (int k = 0; k < 6; k++) begin
            wr(8'h45, k[7:0]);
            repeat (3) @(posedge mclk_in);
            count_ticks(1024);
            cmp(ticks, (k == 0) ? 0 : 1024 >> shifts[k]);
        end
        $display("clock select done");
        for (int k = 7; k >= 6; k--) begin
            wr(8'h45, k[7:0]);
            repeat (6) @(posedge mclk_in);
            total = 0;
            repeat (8) begin
                lfsr = next_rand(lfsr);
                external_count_pin_in <= ~external_count_pin_in;
                count_ticks(8 + lfsr[1:0]);
                total += ticks;
            end
            cmp(total, 4);
        end
        $display("external pin done");
        wr(8'h45, 8'h01);
        wr(8'h43, 8'h81);
        count_ticks(16);
        cmp(ticks, 0);
        rd(8'h43, 8'h81);
        wr(8'h43, 8'h00);
        rd(8'h43, 8'h00);
        wr(8'h43, 8'h01);
        rd(8'h43, 8'h00);
        async_mode_in <= 1'b1;
        wr(8'h43, 8'h02);
        cmp(async_prescaler_reset_out, 1'b1);
        async_reset_done_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        #1;
        cmp(async_prescaler_reset_out, 1'b0);
        wr(8'h43, 8'h82);
        repeat (3) @(posedge mclk_in);
        #1;
        cmp(async_prescaler_reset_out, 1'b1);
        wr(8'h43, 8'h00);
        cmp({sync_prescaler_reset_out, async_prescaler_reset_out}, 2'h0);
        async_reset_done_in <= 1'b0;
        $display("prescaler control done");
        repeat (8) begin
            lfsr = next_rand(lfsr);
            wr(8'h6e, {5'h00, lfsr[2:0]});
            global_irq_enable_in <= lfsr[3];
            events_in <= 3'h7;
            @(posedge mclk_in);
            events_in <= 3'h0;
            repeat (2) @(posedge mclk_in);
            #1;
            cmp(flags_out, 3'h7);
            cmp(irq_req_out, lfsr[3] ? lfsr[2:0] : 3'h0);
            rd(8'h6e, {5'h00, lfsr[2:0]});
            wr(8'h35, 8'h01);
            vector_ack_in <= 3'h2;
            @(posedge mclk_in);
            vector_ack_in <= 3'h0;
            repeat (2) @(posedge mclk_in);
            #1;
            rd(8'h35, 8'h04);
            wr(8'h35, 8'h04);
        end
        $display("flags and interrupts done");
        end_sim();
    end
endmodule : tmc_timer0_ctrl_tb
